// File: hw/bus_status_cfg.svh
// constants for the bus-cycle status encoder
`ifndef BUS_STATUS_CFG_SVH
`define BUS_STATUS_CFG_SVH

`define STAT_W          3
`define STAT_INTA       3'h0
`define STAT_IO_RD      3'h1
`define STAT_IO_WR      3'h2
`define STAT_HALT       3'h3
`define STAT_FETCH      3'h4
`define STAT_MEM_RD     3'h5
`define STAT_MEM_WR     3'h6
`define STAT_PASSIVE    3'h7
`define STAT_RESET_DRV  3'h7
`define OE_ALL          3'h7
`define OE_NONE         3'h0

`define ST_W            7
`define ST_IDLE         7'h01
`define ST_T4           7'h02
`define ST_T1           7'h04
`define ST_T2           7'h08
`define ST_T3           7'h10
`define ST_TW           7'h20
`define ST_HOLD         7'h40

`endif

// File: hw/bus_status_pkg.sv
// types for the bus-cycle status encoder
`include "bus_status_cfg.svh"

package bus_status_pkg;

    typedef enum logic [`STAT_W-1:0] {
        CYC_INTA    = `STAT_INTA,
        CYC_IO_RD   = `STAT_IO_RD,
        CYC_IO_WR   = `STAT_IO_WR,
        CYC_HALT    = `STAT_HALT,
        CYC_FETCH   = `STAT_FETCH,
        CYC_MEM_RD  = `STAT_MEM_RD,
        CYC_MEM_WR  = `STAT_MEM_WR,
        CYC_PASSIVE = `STAT_PASSIVE
    } cycle_code_t;

    typedef enum logic [`ST_W-1:0] {
        BS_IDLE = `ST_IDLE,
        BS_T4   = `ST_T4,
        BS_T1   = `ST_T1,
        BS_T2   = `ST_T2,
        BS_T3   = `ST_T3,
        BS_TW   = `ST_TW,
        BS_HOLD = `ST_HOLD
    } bus_state_t;

endpackage : bus_status_pkg

// File: hw/status_line_drv.sv
// one status line: registered level and registered output enable
`timescale 1ns/100ps

module status_line_drv (
    input  wire logic clk,
    input  wire logic en,
    input  wire logic lvl_d,
    input  wire logic oe_d,
    output logic      lvl_q,
    output logic      oe_q
);

    // the top supplies reset values through lvl_d/oe_d, so no reset here
    always_ff @(posedge clk) begin
        if (en) begin
            lvl_q <= lvl_d;
            oe_q  <= oe_d;
        end
    end

endmodule : status_line_drv

// File: hw/bus_cycle_status_encoder.sv
// bus-cycle status encoder: drives the three status lines for each bus cycle
`timescale 1ns/100ps
`include "bus_status_cfg.svh"

module bus_cycle_status_encoder (
    input  wire logic                         clk,
    input  wire logic                         resetn,
    input  wire logic                         ce,
    input  wire logic                         cyc_req,
    input  wire bus_status_pkg::cycle_code_t  cyc_kind,
    input  wire logic                         ready,
    input  wire logic                         hold_req,
    output logic                              cycle_status_bit2,
    output logic                              cycle_status_bit2_oe,
    output logic                              cycle_status_bit1,
    output logic                              cycle_status_bit1_oe,
    output logic                              cycle_status_bit0,
    output logic                              cycle_status_bit0_oe,
    output logic                              hold_ack_r,
    output logic                              cyc_ack_r,
    output logic                              cyc_done_r,
    output logic                              wait_state_period_r
);

    bus_status_pkg::bus_state_t  state_r;
    bus_status_pkg::bus_state_t  state_nxt;
    logic [`STAT_W-1:0]          stat_q;
    logic [`STAT_W-1:0]          oe_q;
    logic [`STAT_W-1:0]          stat_nxt;
    logic [`STAT_W-1:0]          oe_nxt;
    logic [`STAT_W-1:0]          stat_d;
    logic [`STAT_W-1:0]          oe_d;
    logic                        take;
    logic                        done;
    logic                        rst_seen_r;
    logic                        drv_en;

    assign stat_q = {cycle_status_bit2, cycle_status_bit1, cycle_status_bit0};
    assign oe_q   = {cycle_status_bit2_oe, cycle_status_bit1_oe, cycle_status_bit0_oe};

    // reset acts even while ce is low so the lines cannot be left driven
    assign drv_en = ce | ~resetn;

    // sequencing; the ending T4 is merged with the next cycle's starting T4
    always_comb begin
        state_nxt = state_r;
        stat_nxt  = stat_q;
        oe_nxt    = oe_q;
        take      = 1'b0;
        done      = 1'b0;
        unique case (state_r)
            bus_status_pkg::BS_IDLE: begin
                stat_nxt = `STAT_PASSIVE;
                if (hold_req) begin
                    state_nxt = bus_status_pkg::BS_HOLD;
                    oe_nxt    = `OE_NONE;
                end else if (cyc_req) begin
                    state_nxt = bus_status_pkg::BS_T4;
                    stat_nxt  = cyc_kind;
                    oe_nxt    = `OE_ALL;
                    take      = 1'b1;
                end
            end
            bus_status_pkg::BS_T4: begin
                state_nxt = bus_status_pkg::BS_T1;
            end
            bus_status_pkg::BS_T1: begin
                state_nxt = bus_status_pkg::BS_T2;
            end
            bus_status_pkg::BS_T2: begin
                state_nxt = bus_status_pkg::BS_T3;
                stat_nxt  = `STAT_PASSIVE;
            end
            bus_status_pkg::BS_T3,
            bus_status_pkg::BS_TW: begin
                stat_nxt = `STAT_PASSIVE;
                if (ready) begin
                    done = 1'b1;
                    // hold wins over a pending cycle; granted from idle next clock
                    if (cyc_req && !hold_req) begin
                        state_nxt = bus_status_pkg::BS_T4;
                        stat_nxt  = cyc_kind;
                        oe_nxt    = `OE_ALL;
                        take      = 1'b1;
                    end else begin
                        state_nxt = bus_status_pkg::BS_IDLE;
                    end
                end else begin
                    state_nxt = bus_status_pkg::BS_TW;
                end
            end
            bus_status_pkg::BS_HOLD: begin
                oe_nxt = `OE_NONE;
                if (!hold_req) begin
                    state_nxt = bus_status_pkg::BS_IDLE;
                end
            end
            default: begin
                state_nxt = bus_status_pkg::BS_IDLE;
                stat_nxt  = `STAT_PASSIVE;
                oe_nxt    = `OE_NONE;
            end
        endcase
    end

    // reset override of the line drivers
    always_comb begin
        if (!resetn) begin
            stat_d = `STAT_RESET_DRV;
            oe_d   = rst_seen_r ? `OE_NONE : `OE_ALL;
        end else begin
            stat_d = stat_nxt;
            oe_d   = oe_nxt;
        end
    end

    always_ff @(posedge clk) begin
        if (!resetn) begin
            rst_seen_r <= 1'b1;
        end else if (ce) begin
            rst_seen_r <= 1'b0;
        end
    end

    always_ff @(posedge clk) begin
        if (!resetn) begin
            state_r <= bus_status_pkg::BS_IDLE;
        end else if (ce) begin
            state_r <= state_nxt;
        end
    end

    always_ff @(posedge clk) begin
        if (!resetn) begin
            hold_ack_r          <= 1'b0;
            cyc_ack_r           <= 1'b0;
            cyc_done_r          <= 1'b0;
            wait_state_period_r <= 1'b0;
        end else if (ce) begin
            hold_ack_r          <= (state_nxt == bus_status_pkg::BS_HOLD);
            cyc_ack_r           <= take;
            cyc_done_r          <= done;
            wait_state_period_r <= (state_nxt == bus_status_pkg::BS_TW);
        end
    end

    // line index 2 is the most significant status bit
    status_line_drv u_line2 (
        .clk   (clk),
        .en    (drv_en),
        .lvl_d (stat_d[2]),
        .oe_d  (oe_d[2]),
        .lvl_q (cycle_status_bit2),
        .oe_q  (cycle_status_bit2_oe)
    );

    status_line_drv u_line1 (
        .clk   (clk),
        .en    (drv_en),
        .lvl_d (stat_d[1]),
        .oe_d  (oe_d[1]),
        .lvl_q (cycle_status_bit1),
        .oe_q  (cycle_status_bit1_oe)
    );

    status_line_drv u_line0 (
        .clk   (clk),
        .en    (drv_en),
        .lvl_d (stat_d[0]),
        .oe_d  (oe_d[0]),
        .lvl_q (cycle_status_bit0),
        .oe_q  (cycle_status_bit0_oe)
    );

    property p_code_held_t1;
        @(posedge clk) disable iff (!resetn)
        (state_r == bus_status_pkg::BS_T4 && ce) |=>
            (state_r == bus_status_pkg::BS_T1 && stat_q == $past(stat_q) && oe_q == `OE_ALL);
    endproperty
    a_code_held_t1: assert property (p_code_held_t1) else $error("status code not held into T1");

    property p_code_held_t2;
        @(posedge clk) disable iff (!resetn)
        (state_r == bus_status_pkg::BS_T1 && ce) |=>
            (state_r == bus_status_pkg::BS_T2 && stat_q == $past(stat_q) && oe_q == `OE_ALL);
    endproperty
    a_code_held_t2: assert property (p_code_held_t2) else $error("status code not held into T2");

    property p_passive_late;
        @(posedge clk) disable iff (!resetn)
        (state_r == bus_status_pkg::BS_T3 || state_r == bus_status_pkg::BS_TW) |->
            (stat_q == `STAT_PASSIVE && oe_q == `OE_ALL);
    endproperty
    a_passive_late: assert property (p_passive_late) else $error("status not passive in T3 or wait");

    property p_start_only_t4;
        @(posedge clk) disable iff (!resetn)
        (stat_q != `STAT_PASSIVE && $past(stat_q) == `STAT_PASSIVE && $past(resetn)) |->
            (state_r == bus_status_pkg::BS_T4);
    endproperty
    a_start_only_t4: assert property (p_start_only_t4) else $error("status left passive outside T4");

    property p_hold_float;
        @(posedge clk) disable iff (!resetn)
        (state_r == bus_status_pkg::BS_HOLD) |-> (oe_q == `OE_NONE && hold_ack_r);
    endproperty
    a_hold_float: assert property (p_hold_float) else $error("status lines driven in hold");

    property p_reset_first;
        @(posedge clk) disable iff (1'b0)
        (!resetn && !rst_seen_r) |=> (stat_q == `STAT_RESET_DRV && oe_q == `OE_ALL);
    endproperty
    a_reset_first: assert property (p_reset_first) else $error("lines not driven high on first reset clock");

    property p_reset_float;
        @(posedge clk) disable iff (1'b0)
        (!resetn && $past(!resetn) && rst_seen_r) |=> (oe_q == `OE_NONE);
    endproperty
    a_reset_float: assert property (p_reset_float) else $error("lines not floated later in reset");

    property p_code_value;
        @(posedge clk) disable iff (!resetn)
        (take && ce) |=> (stat_q == $past(cyc_kind) && cyc_ack_r);
    endproperty
    a_code_value: assert property (p_code_value) else $error("status code differs from cycle kind");

    property p_fetch_code;
        @(posedge clk) disable iff (!resetn)
        (take && ce && cyc_kind == bus_status_pkg::CYC_FETCH) |=> (stat_q == `STAT_FETCH);
    endproperty
    a_fetch_code: assert property (p_fetch_code) else $error("fetch cycle not coded 100");

endmodule : bus_cycle_status_encoder

// File: tb/bus_ctrl_model.sv
// behavioural bus controller: decodes status lines and paces ready
`timescale 1ns/100ps

module bus_ctrl_model (
    input  wire logic       clk,
    input  wire logic       resetn,
    input  wire logic [2:0] stat,
    input  wire logic [2:0] stat_oe,
    input  wire logic [1:0] wait_n,
    output logic            ready,
    output logic [2:0]      last_code,
    output logic            mem_rd_cmd
);
    logic [2:0] prev_r;
    logic [3:0] cnt_r;
    // a floating line carries nothing, so only a fully driven pattern is decoded
    wire        drv = (stat_oe === 3'h7);

    always_ff @(posedge clk) begin
        if (!resetn) begin
            prev_r     <= 3'h7;
            cnt_r      <= 4'h0;
            last_code  <= 3'h7;
            mem_rd_cmd <= 1'b0;
        end else begin
            prev_r <= drv ? stat : 3'h7;
            if (drv && stat != 3'h7 && prev_r == 3'h7) begin
                cnt_r      <= 4'h1;
                last_code  <= stat;
                mem_rd_cmd <= (stat == 3'h4) || (stat == 3'h5);
            end else begin
                if (stat == 3'h7 && prev_r != 3'h7) begin
                    mem_rd_cmd <= 1'b0;
                end
                if (cnt_r != 4'hf) begin
                    cnt_r <= cnt_r + 4'h1;
                end
            end
        end
    end

    // wait budget counted from cycle start; high again once spent
    assign ready = (cnt_r >= 4'h3 + {2'h0, wait_n});
endmodule : bus_ctrl_model

// File: tb/bus_cycle_status_encoder_bench.sv
// self-checking bench for the bus-cycle status encoder
`timescale 1ns/100ps

module bus_cycle_status_encoder_bench;
    logic                        clk, resetn, ce, cyc_req, hold_req, ready;
    bus_status_pkg::cycle_code_t cyc_kind;
    logic [1:0]                  wait_n;
    logic [31:0]                 seed;
    wire  [2:0]                  st, oe;
    logic [2:0]                  last_code;
    logic [2:0]                  kq [40];
    logic                        hold_ack_r, cyc_ack_r, cyc_done_r, wait_state_period_r, mem_rd_cmd;
    int                          error_cnt, check_count, i;

    bus_cycle_status_encoder DUT (.clk(clk), .resetn(resetn), .ce(ce), .cyc_req(cyc_req),
        .cyc_kind(cyc_kind), .ready(ready), .hold_req(hold_req),
        .cycle_status_bit2(st[2]), .cycle_status_bit2_oe(oe[2]), .cycle_status_bit1(st[1]),
        .cycle_status_bit1_oe(oe[1]), .cycle_status_bit0(st[0]), .cycle_status_bit0_oe(oe[0]),
        .hold_ack_r(hold_ack_r), .cyc_ack_r(cyc_ack_r), .cyc_done_r(cyc_done_r),
        .wait_state_period_r(wait_state_period_r));

    bus_ctrl_model partner (.clk(clk), .resetn(resetn), .stat(st), .stat_oe(oe), .wait_n(wait_n),
        .ready(ready), .last_code(last_code), .mem_rd_cmd(mem_rd_cmd));

    function automatic logic [31:0] lfsr(input logic [31:0] x);
        return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
    endfunction : lfsr

    task automatic complete_run;
        $display("checks=%0d errors=%0d", check_count, error_cnt);
        if (error_cnt == 0 && check_count > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask : complete_run

    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        check_count++;
        if (got !== exp) begin
            error_cnt++;
            $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk

    task automatic do_reset;
        @(negedge clk);
        resetn = 1'b0;
        cyc_req = 1'b0;
        hold_req = 1'b0;
        @(negedge clk);
        chk({2'h0, oe, st}, 8'h3f);
        @(negedge clk);
        chk({2'h0, oe, st}, 8'h07);
        repeat (10) @(negedge clk);
        resetn = 1'b1;
    endtask : do_reset

    // pending back-to-back request keeps the kind set at the previous ack
    task automatic run_cycle(input int idx, input bit keep);
        logic [2:0] kd;
        int         n;
        if (!cyc_req) cyc_kind = bus_status_pkg::cycle_code_t'(kq[idx]);
        cyc_req = 1'b1;
        for (n = 0; n < 20 && cyc_ack_r !== 1'b1; n++) @(negedge clk);
        if (n == 20) begin
            error_cnt++;
            $display("[ERR] t=%0t got=%h exp=%h", $time, cyc_ack_r, 1'b1);
            complete_run();
        end
        kd = cyc_kind;
        chk({2'h0, oe, st}, {5'h07, kd});
        seed = lfsr(seed);
        wait_n = 2'(seed[7:0] % 3);
        if (keep) cyc_kind = bus_status_pkg::cycle_code_t'(kq[idx + 1]);
        else cyc_req = 1'b0;
        repeat (2) begin
            @(negedge clk);
            chk({2'h0, oe, st}, {5'h07, kd});
        end
        @(negedge clk);
        chk({5'h0, st}, 8'h07);
        chk({4'h0, mem_rd_cmd, last_code}, {4'h0, (kd == 3'h4) || (kd == 3'h5), kd});
        for (n = 0; n < 8; n++) begin
            @(negedge clk);
            if (cyc_done_r === 1'b1) break;
            chk({4'h0, wait_state_period_r, st}, 8'h0f);
        end
        chk(8'(n), {6'h0, wait_n});
        chk({7'h0, mem_rd_cmd}, 8'h00);
    endtask : run_cycle

    initial begin
        clk = 1'b0;
        forever #50 clk = ~clk;
    end

    initial begin
        resetn = 1'b1;
        ce = 1'b1;
        cyc_req = 1'b0;
        hold_req = 1'b0;
        cyc_kind = bus_status_pkg::CYC_PASSIVE;
        wait_n = 2'h0;
        seed = 32'h510b83a1;
        error_cnt = 0;
        check_count = 0;
        for (i = 0; i < 40; i++) begin
            seed = lfsr(seed);
            kq[i] = (i < 7) ? 3'(i) : 3'(seed[15:8] % 7);
        end
        do_reset();
        for (i = 0; i < 30; i++) run_cycle(i, seed[9] && i < 29);
        @(negedge clk);
        ce = 1'b0;
        cyc_req = 1'b1;
        cyc_kind = bus_status_pkg::CYC_FETCH;
        repeat (3) begin
            @(negedge clk);
            chk({7'h0, cyc_ack_r}, 8'h00);
        end
        ce = 1'b1;
        run_cycle(0, 1'b0);
        @(negedge clk);
        hold_req = 1'b1;
        cyc_req = 1'b1;
        cyc_kind = bus_status_pkg::CYC_MEM_RD;
        repeat (5) begin
            @(negedge clk);
            chk({3'h0, hold_ack_r, cyc_ack_r, oe}, 8'h10);
        end
        hold_req = 1'b0;
        @(negedge clk);
        chk({3'h0, hold_ack_r, cyc_ack_r, oe}, 8'h00);
        run_cycle(0, 1'b0);
        do_reset();
        complete_run();
    end
endmodule : bus_cycle_status_encoder_bench
